// ### src/csb_cpu_end.sv
// Processor end: sideband control with Wishbone control and status registers
`include "csb_regs.svh"
module csb_cpu_end (
    input wire logic clk,
    input wire logic rst,
    csb_link_if.cpu link,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq,
    output logic [31:0] fetch_vector,
    output logic int_regs_clear,
    output logic built_in_self_test_run
);
    import csb_pkg::*;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [31:0] vector_reg, vector_next;
    logic [5:0] irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic err_reg, err_next, shut_reg, shut_next;
    logic lock_reg, lock_next;
    logic stall_reg, stall_next;
    logic fp_pend_reg, fp_pend_next;
    logic [31:0] fetch_reg, fetch_next;
    logic clr_reg, clr_next, built_in_self_test_reg, built_in_self_test_next;
    logic rst_seen_reg, rst_seen_next;
    logic init_prev_reg, init_prev_next;
    logic [3:0] sync1_reg, sync2_reg;
    logic maskable_interrupt_request_prev_reg, nmi_prev_reg;
    logic ignore_act, init_act, maskable_interrupt_request_act, nmi_act;
    logic wr, rd;
    logic [5:0] ev;

    ////////////////////////////////////////////////////////////////
    // Two-flop synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {link.local_interrupt_pins, ~link.init_n, ~link.numeric_error_ignore_n};
            sync2_reg <= sync1_reg;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////
    always_comb begin
        ignore_act = sync2_reg[0];
        init_act = sync2_reg[1];
        maskable_interrupt_request_act = sync2_reg[2];
        nmi_act = sync2_reg[3];
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
        rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        ctrl_next = ctrl_reg;
        vector_next = vector_reg;
        irq_en_next = irq_en_reg;
        if (wr && wb_adr_i == `CSB_ADDR_CTRL) begin
            ctrl_next = 8'(merge({24'h0, ctrl_reg}, wb_dat_i, wb_sel_i));
        end
        if (wr && wb_adr_i == `CSB_ADDR_VECTOR) begin
            vector_next = merge(vector_reg, wb_dat_i, wb_sel_i);
        end
        if (wr && wb_adr_i == `CSB_ADDR_IRQ_EN) begin
            irq_en_next = 6'(merge({26'h0, irq_en_reg}, wb_dat_i, wb_sel_i));
        end
        err_next = err_reg | ctrl_reg[`CSB_CTRL_ERR];
        shut_next = ctrl_reg[`CSB_CTRL_ERR] & ~err_reg;
        lock_next = ctrl_reg[`CSB_CTRL_LOCK];
        // Stall pair, held bit extends it
        stall_next = ctrl_reg[`CSB_CTRL_SNOOP_STALL];
        fp_pend_next = fp_pend_reg | ctrl_reg[`CSB_CTRL_FP_ERR];
        ev = 6'h0;
        if (ctrl_reg[`CSB_CTRL_FP_EXEC] && fp_pend_reg &&
                (ctrl_reg[`CSB_CTRL_NE] || !ignore_act)) begin
            ev[`CSB_EV_EXC] = 1'b1;
            // New error in the same cycle wins over the clear
            fp_pend_next = ctrl_reg[`CSB_CTRL_FP_ERR];
        end
        ev[`CSB_EV_MASKABLE_INTERRUPT_REQUEST] = ~ctrl_reg[`CSB_CTRL_LIC_EN] & maskable_interrupt_request_act & ~maskable_interrupt_request_prev_reg;
        ev[`CSB_EV_NMI] = ~ctrl_reg[`CSB_CTRL_LIC_EN] & nmi_act & ~nmi_prev_reg;
        init_prev_next = init_act;
        clr_next = init_act & ~init_prev_reg;
        fetch_next = (init_act & ~init_prev_reg) ? vector_reg : fetch_reg;
        ev[`CSB_EV_INIT] = clr_next;
        ev[`CSB_EV_SNOOP] = (~link.hit_n | ~link.snoop_hit_modified_n);
        rst_seen_next = link.rst_bus;
        built_in_self_test_next = rst_seen_reg & ~link.rst_bus & init_act;
        ev[`CSB_EV_BUILT_IN_SELF_TEST] = built_in_self_test_next;
        irq_stat_next = irq_stat_reg | ev;
        if (wr && wb_adr_i == `CSB_ADDR_IRQ_CLR) begin
            // Set wins over clear
            irq_stat_next = (irq_stat_reg & ~wb_dat_i[5:0]) | ev;
        end
        unique case (wb_adr_i)
            `CSB_ADDR_CTRL: dat_next = {24'h0, ctrl_reg};
            `CSB_ADDR_STAT: dat_next = {26'h0, init_act, ignore_act, fp_pend_reg, lock_reg, err_reg,
                stall_reg};
            `CSB_ADDR_IRQ_STAT: dat_next = {26'h0, irq_stat_reg};
            `CSB_ADDR_IRQ_EN: dat_next = {26'h0, irq_en_reg};
            `CSB_ADDR_VECTOR: dat_next = vector_reg;
            default: dat_next = 32'h0;
        endcase
        if (!rd) begin
            dat_next = dat_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= 8'(`CSB_CTRL_RESET);
            vector_reg <= `CSB_VECTOR_RESET;
            irq_stat_reg <= 6'h0;
            irq_en_reg <= 6'h0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            err_reg <= 1'b0;
            shut_reg <= 1'b0;
            lock_reg <= 1'b0;
            stall_reg <= 1'b0;
            fp_pend_reg <= 1'b0;
            fetch_reg <= `CSB_VECTOR_RESET;
            clr_reg <= 1'b0;
            built_in_self_test_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
            init_prev_reg <= 1'b0;
            maskable_interrupt_request_prev_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            vector_reg <= vector_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            err_reg <= err_next;
            shut_reg <= shut_next;
            lock_reg <= lock_next;
            stall_reg <= stall_next;
            fp_pend_reg <= fp_pend_next;
            fetch_reg <= fetch_next;
            clr_reg <= clr_next;
            built_in_self_test_reg <= built_in_self_test_next;
            rst_seen_reg <= rst_seen_next;
            init_prev_reg <= init_prev_next;
            maskable_interrupt_request_prev_reg <= maskable_interrupt_request_act;
            nmi_prev_reg <= nmi_act;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        link.hit_n_p_o = 1'b0;
        link.hit_n_p_oe = stall_reg;
        link.snoop_hit_modified_n_n_p_o = 1'b0;
        link.snoop_hit_modified_n_n_p_oe = stall_reg;
        link.lock_n_p_o = 1'b0;
        link.lock_n_p_oe = lock_reg;
        link.internal_error_n = ~err_reg;
        link.shutdown = shut_reg;
        // Debug clock copy; a gate, not a compensated buffer
        link.debug_clock_out_p = clk;
        link.debug_clock_out_n = ~clk;
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq = |(irq_stat_reg & irq_en_reg);
    assign fetch_vector = fetch_reg;
    assign int_regs_clear = clr_reg;
    assign built_in_self_test_run = built_in_self_test_reg;
endmodule : csb_cpu_end

// ### src/csb_regs.svh
// Constants for the processor sideband control block
// Notes on behaviour
// - Snoop stall: hit and hit-modified together
// - Repeated pair extends stall
// - Internal error held until reset
// - Shutdown issued with internal error
// - Ignore input active: pending error ignored
// - Ignore inactive: pending error raises exception
// - Native numeric-error bit disables ignore input
// - Ignore valid at target-ready of write
// - Warm init resets integer state only
// - Resume at configured reset vector
// - Snoops serviced during warm init
// - Init at reset release runs self-test
// - Debug clock copies bus clock
// - Controller off: pins become interrupt requests
// - Controller enabled after reset
// - Lock held across whole locked sequence
// - Priority agent waits for lock release
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH
`define CSB_ADDR_CTRL 4'h0
`define CSB_ADDR_STAT 4'h1
`define CSB_ADDR_IRQ_STAT 4'h2
`define CSB_ADDR_IRQ_CLR 4'h3
`define CSB_ADDR_IRQ_EN 4'h4
`define CSB_ADDR_VECTOR 4'h5
`define CSB_CTRL_SNOOP_STALL 0
`define CSB_CTRL_ERR 1
`define CSB_CTRL_FP_ERR 2
`define CSB_CTRL_FP_EXEC 3
`define CSB_CTRL_NE 4
`define CSB_CTRL_LIC_EN 5
`define CSB_CTRL_LOCK 6
`define CSB_CTRL_INIT 7
`define CSB_CTRL_RESET 32'h0000_0020
`define CSB_VECTOR_RESET 32'hFFFF_FFF0
`define CSB_EV_EXC 0
`define CSB_EV_MASKABLE_INTERRUPT_REQUEST 1
`define CSB_EV_NMI 2
`define CSB_EV_BUILT_IN_SELF_TEST 3
`define CSB_EV_INIT 4
`define CSB_EV_SNOOP 5
`endif

// ### src/csb_pkg.sv
// Types shared by both ends of the sideband link
package csb_pkg;
    typedef enum logic [1:0] {
        CSB_SNOOP_CLEAN = 2'b00,
        CSB_SNOOP_HIT = 2'b01,
        CSB_SNOOP_MOD = 2'b10,
        CSB_SNOOP_STALL = 2'b11
    } csb_snoop_t;
endpackage : csb_pkg

// ### src/csb_link_if.sv
// Sideband wires between processor and system logic
interface csb_link_if;
    logic hit_n_p_o, hit_n_p_oe, snoop_hit_modified_n_n_p_o, snoop_hit_modified_n_n_p_oe;
    logic hit_n_s_o, hit_n_s_oe, snoop_hit_modified_n_n_s_o, snoop_hit_modified_n_n_s_oe;
    logic lock_n_p_o, lock_n_p_oe, lock_n_s_o, lock_n_s_oe;
    logic internal_error_n, shutdown;
    logic numeric_error_ignore_n, init_n, rst_bus;
    logic [1:0] local_interrupt_pins;
    logic priority_bus_request_n, target_ready_n, debug_clock_out_p, debug_clock_out_n;
    // Open-drain wired AND of both drivers
    wire hit_n = ~((hit_n_p_oe & ~hit_n_p_o) | (hit_n_s_oe & ~hit_n_s_o));
    wire snoop_hit_modified_n = ~((snoop_hit_modified_n_n_p_oe & ~snoop_hit_modified_n_n_p_o) | (snoop_hit_modified_n_n_s_oe & ~snoop_hit_modified_n_n_s_o));
    wire lock_n = ~((lock_n_p_oe & ~lock_n_p_o) | (lock_n_s_oe & ~lock_n_s_o));
    modport cpu (output hit_n_p_o, hit_n_p_oe, snoop_hit_modified_n_n_p_o, snoop_hit_modified_n_n_p_oe, lock_n_p_o, lock_n_p_oe,
        internal_error_n, shutdown, debug_clock_out_p, debug_clock_out_n,
        input hit_n, snoop_hit_modified_n, lock_n, numeric_error_ignore_n, init_n, rst_bus,
        local_interrupt_pins, priority_bus_request_n, target_ready_n);
    modport sys (output hit_n_s_o, hit_n_s_oe, snoop_hit_modified_n_n_s_o, snoop_hit_modified_n_n_s_oe, lock_n_s_o, lock_n_s_oe,
        numeric_error_ignore_n, init_n, rst_bus, local_interrupt_pins, priority_bus_request_n,
        target_ready_n,
        input hit_n, snoop_hit_modified_n, lock_n, internal_error_n, shutdown);
endinterface : csb_link_if

// ### src/csb_sys_end.sv
// System logic end: stall, bus reset, priority request and sideband drive
`include "csb_regs.svh"
module csb_sys_end (
    input wire logic clk,
    input wire logic rst,
    csb_link_if.sys link,
    input wire logic user_stall,
    input wire logic user_bus_reset,
    input wire logic user_init,
    input wire logic user_ignore,
    input wire logic [1:0] user_lint,
    input wire logic user_io_write_ready,
    input wire logic user_prio_req,
    output logic user_prio_grant,
    output logic user_cpu_error,
    output logic user_nmi_from_shutdown,
    output csb_pkg::csb_snoop_t user_snoop_seen
);
    import csb_pkg::*;
    logic grant_reg, grant_next, err_reg, err_next, nmi_reg, nmi_next;
    csb_snoop_t seen_reg, seen_next;
    logic ignore_reg, ignore_next;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        link.hit_n_s_o = 1'b0;
        link.hit_n_s_oe = user_stall;
        link.snoop_hit_modified_n_n_s_o = 1'b0;
        link.snoop_hit_modified_n_n_s_oe = user_stall;
        link.lock_n_s_o = 1'b1;
        link.lock_n_s_oe = 1'b0;
        link.init_n = ~user_init;
        link.rst_bus = user_bus_reset;
        link.local_interrupt_pins = user_lint;
        link.priority_bus_request_n = ~user_prio_req;
        link.target_ready_n = ~user_io_write_ready;
        link.numeric_error_ignore_n = ~ignore_reg;
        ignore_next = user_io_write_ready ? user_ignore : ignore_reg;
        grant_next = user_prio_req & link.lock_n;
        err_next = ~link.internal_error_n;
        nmi_next = link.shutdown;
        seen_next = csb_snoop_t'({~link.snoop_hit_modified_n, ~link.hit_n});
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant_reg <= 1'b0;
            err_reg <= 1'b0;
            nmi_reg <= 1'b0;
            seen_reg <= CSB_SNOOP_CLEAN;
            ignore_reg <= 1'b0;
        end else begin
            grant_reg <= grant_next;
            err_reg <= err_next;
            nmi_reg <= nmi_next;
            seen_reg <= seen_next;
            ignore_reg <= ignore_next;
        end
    end

    assign user_prio_grant = grant_reg;
    assign user_cpu_error = err_reg;
    assign user_nmi_from_shutdown = nmi_reg;
    assign user_snoop_seen = seen_reg;
endmodule : csb_sys_end

// ### tb/csb_link_monitor.sv
// Checker on the sideband link wires
module csb_link_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic hit_n,
    input wire logic snoop_hit_modified_n,
    input wire logic lock_n,
    input wire logic hit_n_p_oe,
    input wire logic snoop_hit_modified_n_n_p_oe,
    input wire logic hit_n_s_oe,
    input wire logic snoop_hit_modified_n_n_s_oe,
    input wire logic lock_n_p_oe,
    input wire logic internal_error_n,
    input wire logic shutdown,
    input wire logic rst_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    AST_ERR_HOLD: assert property (!internal_error_n && !rst_bus |=> !internal_error_n)
        else $error("error output released");
    AST_ERR_RESET: assert property ($fell(rst) |-> internal_error_n && !hit_n_p_oe && !lock_n_p_oe)
        else $error("link not idle after reset");
    AST_SHUT_ERR: assert property (shutdown |-> ##[0:1] !internal_error_n)
        else $error("shutdown without error");
    AST_SHUT_PULSE: assert property (shutdown |=> !shutdown)
        else $error("shutdown too long");
    AST_PAIR_CPU: assert property (hit_n_p_oe == snoop_hit_modified_n_n_p_oe)
        else $error("cpu stall pins split");
    AST_PAIR_SYS: assert property (hit_n_s_oe == snoop_hit_modified_n_n_s_oe)
        else $error("sys stall pins split");
    AST_STALL_WIRE: assert property (hit_n_p_oe |-> !hit_n && !snoop_hit_modified_n)
        else $error("stall not on wires");
    AST_LOCK_WIRE: assert property (lock_n_p_oe |-> !lock_n)
        else $error("lock not on wire");
endmodule : csb_link_monitor

// ### tb/csb_tb.sv
// Bench joining both sideband ends over the link
module csb_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import csb_pkg::*;
    logic clk = 1'h0, rst = 1'h1, user_stall = 1'h0, user_bus_reset = 1'h0, user_init = 1'h0;
    logic user_ignore = 1'h0, user_io_write_ready = 1'h0, user_prio_req = 1'h0;
    logic wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic [1:0] user_lint = 2'h0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, fetch_vector, n_clr = 32'h0, n_built_in_self_test = 32'h0, n_nmi = 32'h0;
    logic wb_ack_o, irq, int_regs_clear, built_in_self_test_run, user_prio_grant, user_cpu_error, user_nmi_from_shutdown;
    csb_snoop_t user_snoop_seen;
    int n_errors = 0, checked = 0, cycles = 0;
    csb_link_if link ();
    csb_sys_end u_csb_sys_end (.clk, .rst, .link(link.sys), .user_stall, .user_bus_reset, .user_init,
        .user_ignore, .user_lint, .user_io_write_ready, .user_prio_req, .user_prio_grant, .user_cpu_error,
        .user_nmi_from_shutdown, .user_snoop_seen);
    csb_cpu_end u_csb_cpu_end (.clk, .rst, .link(link.cpu), .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq, .fetch_vector, .int_regs_clear, .built_in_self_test_run);
    csb_link_monitor u_csb_link_monitor (.clk, .rst, .hit_n(link.hit_n),
        .snoop_hit_modified_n(link.snoop_hit_modified_n), .lock_n(link.lock_n),
        .hit_n_p_oe(link.hit_n_p_oe), .snoop_hit_modified_n_n_p_oe(link.snoop_hit_modified_n_n_p_oe), .hit_n_s_oe(link.hit_n_s_oe),
        .snoop_hit_modified_n_n_s_oe(link.snoop_hit_modified_n_n_s_oe), .lock_n_p_oe(link.lock_n_p_oe),
        .internal_error_n(link.internal_error_n), .shutdown(link.shutdown), .rst_bus(link.rst_bus));
    ////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;
    // Pulse counters; a hung run is cut short
    always @(posedge clk) begin
        n_clr <= n_clr + 32'(int_regs_clear === 1'h1);
        n_built_in_self_test <= n_built_in_self_test + 32'(built_in_self_test_run === 1'h1);
        n_nmi <= n_nmi + 32'(user_nmi_from_shutdown === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            $display("unexpected at %0t: timeout", $time);
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : ck
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // Classic cycle held until ack is sampled
    task automatic bus(input logic [3:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] q;
        bus(a, 1'h0, 32'h0, q);
        ck(q & m, e);
    endtask : rc
    task automatic ign(input logic v);
        user_ignore <= v;
        user_io_write_ready <= 1'h1;
        w(1);
        user_io_write_ready <= 1'h0;
        w(4);
    endtask : ign
    task automatic lp(input logic [1:0] v);
        user_lint <= v;
        w(5);
        user_lint <= 2'h0;
        w(4);
    endtask : lp
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rc(4'h0, 32'h20, 32'hFF);
        rc(4'h5, 32'hFFFF_FFF0);
        wr(4'hF, 32'h55);
        rc(4'hF, 32'h0);
        // Low phase, away from the edge
        @(negedge clk);
        #1;
        ck(32'(link.debug_clock_out_p), 32'h0);
        ck(32'(link.debug_clock_out_n), 32'h1);
        @(posedge clk);
    endtask : t_reset
    task automatic t_stall;
        wr(4'h0, 32'h21);
        w(3);
        ck(32'(user_snoop_seen), 32'(CSB_SNOOP_STALL));
        w(6);
        ck(32'(user_snoop_seen), 32'(CSB_SNOOP_STALL));
        wr(4'h0, 32'h20);
        w(3);
        ck(32'(user_snoop_seen), 32'(CSB_SNOOP_CLEAN));
    endtask : t_stall
    task automatic t_fp;
        wr(4'h4, 32'h3F);
        ign(1'h1);
        wr(4'h0, 32'h2C);
        w(4);
        rc(4'h2, 32'h0, 32'h1);
        wr(4'h0, 32'h3C);
        w(4);
        rc(4'h2, 32'h1, 32'h1);
        wr(4'h0, 32'h20);
        wr(4'h3, 32'h3F);
        w(2);
        ck(32'(irq), 32'h0);
        ign(1'h0);
        wr(4'h0, 32'h2C);
        w(4);
        rc(4'h2, 32'h1, 32'h1);
        ck(32'(irq), 32'h1);
        wr(4'h4, 32'h0);
        ck(32'(irq), 32'h0);
        wr(4'h4, 32'h3F);
        wr(4'h0, 32'h20);
        wr(4'h3, 32'h3F);
    endtask : t_fp
    task automatic t_lint;
        lp(2'h3);
        rc(4'h2, 32'h0, 32'h6);
        wr(4'h0, 32'h0);
        lp(2'h1);
        rc(4'h2, 32'h2, 32'h6);
        lp(2'h2);
        rc(4'h2, 32'h6, 32'h6);
        wr(4'h0, 32'h20);
    endtask : t_lint
    task automatic t_lock;
        wr(4'h0, 32'h60);
        user_prio_req <= 1'h1;
        w(8);
        ck(32'(user_prio_grant), 32'h0);
        wr(4'h0, 32'h20);
        w(4);
        ck(32'(user_prio_grant), 32'h1);
        user_prio_req <= 1'h0;
    endtask : t_lock
    // Snoops keep flowing while init is held
    task automatic t_init;
        wr(4'h5, 32'h0000_1230);
        wr(4'h3, 32'h3F);
        user_init <= 1'h1;
        user_stall <= 1'h1;
        w(6);
        ck(fetch_vector, 32'h0000_1230);
        ck(n_clr, 32'h1);
        rc(4'h1, 32'h20, 32'h23);
        rc(4'h2, 32'h30, 32'h38);
        user_stall <= 1'h0;
        user_init <= 1'h0;
        w(4);
    endtask : t_init
    task automatic t_built_in_self_test;
        user_bus_reset <= 1'h1;
        w(4);
        user_bus_reset <= 1'h0;
        w(4);
        ck(n_built_in_self_test, 32'h0);
        user_bus_reset <= 1'h1;
        user_init <= 1'h1;
        w(4);
        user_bus_reset <= 1'h0;
        w(4);
        ck(n_built_in_self_test, 32'h1);
        user_init <= 1'h0;
        w(4);
    endtask : t_built_in_self_test
    // Second reset in mid-run is the only way out of an error
    task automatic t_error;
        wr(4'h0, 32'h22);
        w(4);
        ck(32'(user_cpu_error), 32'h1);
        ck(n_nmi, 32'h1);
        wr(4'h0, 32'h20);
        w(6);
        ck(32'(user_cpu_error), 32'h1);
        rst <= 1'h1;
        w(2);
        rst <= 1'h0;
        w(4);
        ck(32'(user_cpu_error), 32'h0);
        rc(4'h0, 32'h20, 32'hFF);
    endtask : t_error
    initial begin
        w(5);
        rst <= 1'h0;
        w(1);
        t_reset;
        t_stall;
        t_fp;
        t_lint;
        t_lock;
        t_init;
        t_built_in_self_test;
        t_error;
        tally_and_finish;
    end
endmodule : csb_tb
